// ==== hw/fsp_pkg.sv ====
// Shared constants and types for the serial memory SPI slave port.
// Assumes one 200 MHz system clock; the SPI pins are asynchronous to it.
package fsp_pkg;
	// Array geometry
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int ADDR_BYTES = 3;
	localparam int MEM_WORDS = 262144;
	// Write FIFO entry: address above data
	localparam int FIFO_W = ADDR_W + DATA_W;
	localparam int FIFO_DEPTH = 16;
	// Timing: system clock and fastest serial clock
	localparam int CLK_MHZ = 200;
	localparam int SCK_MAX_MHZ = 25;
	localparam int SCK_HALF_CYC = CLK_MHZ / (2 * SCK_MAX_MHZ);
	// Command opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ_ID = 8'h9F;
	// Status register fields
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 3;
	localparam int SR_PPEN = 7;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] SR_WRITABLE = 8'h8C;
	// Block protect boundaries
	localparam logic [ADDR_W-1:0] QUARTER_BASE = 18'h30000;
	localparam logic [ADDR_W-1:0] HALF_BASE = 18'h20000;
	// Identification length in bytes
	localparam int ID_BYTES = 4;
	// Port sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WRDATA, ST_STSWR, ST_RDDATA, ST_DISCARD
	} fsp_state_t;
	// Source of bytes shifted out
	typedef enum logic [1:0] {SRC_MEM, SRC_STATUS, SRC_ID} fsp_src_t;
endpackage : fsp_pkg

// ==== hw/fsp_stream_if.sv ====
// Valid/ready byte-write stream between the port, its FIFO and the array.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface fsp_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : fsp_stream_if

// ==== hw/fsp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module fsp_fifo #(parameter int W = 8, parameter int DEPTH = 16)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Streams
	fsp_stream_if.snk inS,
	fsp_stream_if.src outS
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [PW:0] count;
	logic doPush;
	logic doPop;

	// Honest full and empty from the fill count
	assign inS.ready = (count != (PW+1)'(DEPTH));
	assign outS.valid = (count != '0);
	assign outS.data = store[rdPtr];
	assign doPush = inS.valid & inS.ready;
	assign doPop = outS.valid & outS.ready;

	// Storage write
	always_ff @(posedge clock)
	begin
		if (doPush)
			store[wrPtr] <= inS.data;
	end

	// Pointers and count
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr <= wrPtr + 1'b1;
			if (doPop)
				rdPtr <= rdPtr + 1'b1;
			if (doPush && !doPop)
				count <= count + 1'b1;
			else if (doPop && !doPush)
				count <= count - 1'b1;
		end
	end
endmodule : fsp_fifo

// ==== hw/fsp_array.sv ====
// Byte-wide storage array with one read port and a drained write stream.
// Assumes reads are rare pulses; a read stalls the write drain for that cycle.
`timescale 1ns/1ps
module fsp_array
	import fsp_pkg::*;
(
	// Clock
	input wire logic clock,
	// Read port, data one cycle after the request
	input wire logic rdEn,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData,
	// Write stream
	fsp_stream_if.snk wrS
);
	logic [DATA_W-1:0] mem [MEM_WORDS];

	// Read has priority so output bytes are never late
	assign wrS.ready = !rdEn;

	// Array access
	always_ff @(posedge clock)
	begin
		if (wrS.valid && !rdEn)
			mem[wrS.data[FIFO_W-1:DATA_W]] <= wrS.data[DATA_W-1:0];
		if (rdEn)
			rdData <= mem[rdAddr];
	end
endmodule : fsp_array

// ==== hw/fsp_port.sv ====
// SPI slave port of a byte-wide nonvolatile memory, with write FIFO and array.
// Assumes the SPI pins are asynchronous and the serial clock is at most an
// eighth of the system clock rate, four system clocks per half period.
`timescale 1ns/1ps
module fsp_port
	import fsp_pkg::*;
#(
	// Identification bytes; value arbitrary
	parameter logic [8*ID_BYTES-1:0] ID_CODE = 32'h5A01C3E7
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// SPI pins
	input wire logic sckPin,
	input wire logic selectN,
	input wire logic siPin,
	output logic soData,
	output logic soOe,
	// Control pins
	input wire logic writeProtectN,
	input wire logic holdN,
	// Status
	output logic spiMode3,
	output logic [7:0] statusReg
);
	// Pin synchronisers
	logic sckS1, sckS2, sckPrev;
	logic csS1, csS2, csEff;
	logic siS1, siS2;
	logic holdS1, holdS2;
	logic wpS1, wpS2;
	// Edges
	logic sckRise, sckFall, selStart, selEnd;
	// Receive
	logic [7:0] rxShift;
	logic [2:0] bitCnt;
	logic byteDone;
	logic [7:0] rxByte;
	// Sequencer
	fsp_state_t state;
	logic [7:0] opcode;
	logic [1:0] addrCnt;
	logic [ADDR_W-1:0] addr;
	fsp_src_t src;
	logic [2:0] idIdx;
	// Transmit
	logic fetchReq, fetchValid;
	logic [7:0] nextByte;
	logic [7:0] txShift;
	logic [2:0] outCnt;
	logic soDrive;
	logic [DATA_W-1:0] memRdData;
	// Write push
	logic pushValid;
	logic [FIFO_W-1:0] pushData;
	logic writeOk, statusOk;

	fsp_stream_if #(.W(FIFO_W)) toFifo ();
	fsp_stream_if #(.W(FIFO_W)) toArray ();

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			{sckS1, sckS2, sckPrev} <= 3'h0;
			{csS1, csS2} <= 2'h3;
			{siS1, siS2} <= 2'h0;
			{holdS1, holdS2} <= 2'h3;
			{wpS1, wpS2} <= 2'h3;
		end
		else
		begin
			sckS1 <= sckPin;
			sckS2 <= sckS1;
			sckPrev <= sckS2;
			csS1 <= selectN;
			csS2 <= csS1;
			siS1 <= siPin;
			siS2 <= siS1;
			holdS1 <= holdN;
			holdS2 <= holdS1;
			wpS1 <= writeProtectN;
			wpS2 <= wpS1;
		end
	end

	// Edges count only while selected and not held
	assign sckRise = sckS2 & !sckPrev & !csEff & holdS2;
	assign sckFall = !sckS2 & sckPrev & !csEff & holdS2;
	assign selStart = csEff & !csS2 & holdS2;
	assign selEnd = !csEff & csS2 & holdS2;
	assign rxByte = {rxShift[6:0], siS2};
	assign byteDone = sckRise && bitCnt == 3'h7;

	// Select level is frozen while held, so a select change then takes effect only once hold is released
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			csEff <= 1'b1;
			spiMode3 <= 1'b0;
		end
		else if (holdS2)
		begin
			csEff <= csS2;
			if (selStart)
				spiMode3 <= sckS2;
		end
	end

	// Receive shifter; no state depends on clock idle level, so both modes work
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rxShift <= 8'h00;
			bitCnt <= 3'h0;
		end
		else if (selStart)
			bitCnt <= 3'h0;
		else if (sckRise)
		begin
			rxShift <= rxByte;
			bitCnt <= bitCnt + 3'h1;
		end
	end

	// Write permission: latch set and target outside the protected block
	always_comb
	begin
		writeOk = statusReg[SR_WEL];
		case (statusReg[SR_BP_HI:SR_BP_LO])
			2'h1: writeOk = writeOk && addr < QUARTER_BASE;
			2'h2: writeOk = writeOk && addr < HALF_BASE;
			2'h3: writeOk = 1'b0;
			default: writeOk = writeOk;
		endcase
		statusOk = statusReg[SR_WEL] && !(statusReg[SR_PPEN] && !wpS2);
	end

	// Command sequencer
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			opcode <= 8'h00;
			addrCnt <= 2'h0;
			addr <= '0;
			src <= SRC_MEM;
			idIdx <= 3'h0;
		end
		else if (selStart)
			state <= ST_OPCODE;
		else if (selEnd)
			state <= ST_IDLE;
		else if (byteDone)
		begin
			case (state)
				ST_OPCODE:
				begin
					opcode <= rxByte;
					addrCnt <= 2'h0;
					idIdx <= 3'h0;
					if (rxByte == OP_WRITE_ENABLE || rxByte == OP_WRITE_DISABLE)
						state <= ST_DISCARD;
					else if (rxByte == OP_READ_STATUS)
					begin
						src <= SRC_STATUS;
						state <= ST_RDDATA;
					end
					else if (rxByte == OP_READ_ID)
					begin
						src <= SRC_ID;
						state <= ST_RDDATA;
					end
					else if (rxByte == OP_WRITE_STATUS)
						state <= ST_STSWR;
					else if (rxByte == OP_READ || rxByte == OP_FAST_READ || rxByte == OP_WRITE)
					begin
						src <= SRC_MEM;
						state <= ST_ADDR;
					end
					else
						state <= ST_DISCARD;
				end
				ST_ADDR:
				begin
					// Top six address bits fall off the end
					addr <= {addr[ADDR_W-9:0], rxByte};
					addrCnt <= addrCnt + 2'h1;
					if (addrCnt == 2'(ADDR_BYTES - 1))
					begin
						if (opcode == OP_WRITE)
							state <= ST_WRDATA;
						else if (opcode == OP_FAST_READ)
							state <= ST_DUMMY;
						else
							state <= ST_RDDATA;
					end
				end
				ST_DUMMY: state <= ST_RDDATA;
				ST_WRDATA: addr <= addr + 1'b1;
				ST_STSWR: state <= ST_DISCARD;
				default: state <= state;
			endcase
		end
		else if (fetchReq)
		begin
			// Advance after each fetch so the next byte is always ready
			if (src == SRC_MEM)
				addr <= addr + 1'b1;
			if (src == SRC_ID && idIdx != 3'(ID_BYTES))
				idIdx <= idIdx + 3'h1;
		end
	end

	// Status register; latch set by enable, cleared by disable or a finished write
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			statusReg <= SR_RESET;
		else if (byteDone && state == ST_OPCODE && rxByte == OP_WRITE_ENABLE)
			statusReg[SR_WEL] <= 1'b1;
		else if (byteDone && state == ST_OPCODE && rxByte == OP_WRITE_DISABLE)
			statusReg[SR_WEL] <= 1'b0;
		else if (byteDone && state == ST_STSWR && statusOk)
			statusReg <= (statusReg & ~SR_WRITABLE) | (rxByte & SR_WRITABLE);
		else if (selEnd && (opcode == OP_WRITE || opcode == OP_WRITE_STATUS))
			statusReg[SR_WEL] <= 1'b0;
	end

	// Hold one received byte until the FIFO takes it
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pushValid <= 1'b0;
			pushData <= '0;
		end
		else if (byteDone && state == ST_WRDATA && writeOk)
		begin
			pushValid <= 1'b1;
			pushData <= {addr, rxByte};
		end
		else if (toFifo.ready)
			pushValid <= 1'b0;
	end
	assign toFifo.valid = pushValid;
	assign toFifo.data = pushData;

	// Fetch the next outgoing byte on entry to the read phase and at each byte start
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			fetchReq <= 1'b0;
			fetchValid <= 1'b0;
			nextByte <= 8'h00;
		end
		else
		begin
			fetchReq <= (byteDone && (state == ST_ADDR || state == ST_DUMMY || state == ST_OPCODE)
				&& state != ST_RDDATA && (state == ST_OPCODE ? (rxByte == OP_READ_STATUS
				|| rxByte == OP_READ_ID) : (addrCnt == 2'(ADDR_BYTES - 1) && opcode == OP_READ)
				|| state == ST_DUMMY)) || (sckFall && state == ST_RDDATA && outCnt == 3'h0);
			fetchValid <= fetchReq;
			if (fetchValid)
			begin
				case (src)
					SRC_STATUS: nextByte <= statusReg;
					SRC_ID: nextByte <= (idIdx == 3'h0) ? 8'h00
						: ID_CODE[8*(ID_BYTES-32'(idIdx)+1)-1 -: 8];
					default: nextByte <= memRdData;
				endcase
			end
		end
	end

	// Shift out on falling edges, MSB first
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			soData <= 1'b0;
			txShift <= 8'h00;
			outCnt <= 3'h0;
			soDrive <= 1'b0;
		end
		else if (selStart || selEnd)
		begin
			outCnt <= 3'h0;
			soDrive <= 1'b0;
		end
		else if (sckFall && state == ST_RDDATA)
		begin
			soDrive <= 1'b1;
			outCnt <= outCnt + 3'h1;
			if (outCnt == 3'h0)
			begin
				soData <= nextByte[7];
				txShift <= {nextByte[6:0], 1'b0};
			end
			else
			begin
				soData <= txShift[7];
				txShift <= {txShift[6:0], 1'b0};
			end
		end
	end

	// Output enable; tristated when deselected, held or not reading
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			soOe <= 1'b0;
		else
			soOe <= soDrive && !csEff && holdS2 && state == ST_RDDATA;
	end

	fsp_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) writeFifo (
		.clock(clock),
		.rst_n(rst_n),
		.inS(toFifo),
		.outS(toArray)
	);

	fsp_array storage (
		.clock(clock),
		.rdEn(fetchReq && src == SRC_MEM),
		.rdAddr(addr),
		.rdData(memRdData),
		.wrS(toArray)
	);
endmodule : fsp_port

// ==== verif/fsp_port_props.sv ====
// Pin checker for the SPI slave port.
// Assumes it is bound to fsp_port and sees only its ports.
`timescale 1ns/1ps
module fsp_port_props
	import fsp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// SPI pins
	input wire logic sckPin,
	input wire logic selectN,
	input wire logic siPin,
	input wire logic soData,
	input wire logic soOe,
	// Control and status
	input wire logic writeProtectN,
	input wire logic holdN,
	input wire logic spiMode3,
	input wire logic [7:0] statusReg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	int sinceFall;
	int wpLow;
	// Cycles since a serial fall and protect-pin low time, saturating
	always_ff @(posedge clock)
	begin
		sinceFall <= $fell(sckPin) ? 0 : (sinceFall < 99 ? sinceFall + 1 : sinceFall);
		wpLow <= writeProtectN ? 0 : (wpLow < 99 ? wpLow + 1 : wpLow);
	end
	AST_DESEL_QUIET: assert property (selectN [*6] |-> !soOe)
		else $error("output driven while deselected");
	AST_IDLE_STATUS: assert property (selectN [*8] |-> $stable(statusReg))
		else $error("status moved while deselected");
	AST_OUT_ON_FALL: assert property ($changed(soData) && soOe |-> sinceFall <= 6)
		else $error("output changed away from a serial fall");
	AST_HOLD_QUIET: assert property ((!holdN) [*6] |-> !soOe)
		else $error("output driven during hold");
	AST_OE_SELECTED: assert property ($rose(soOe) |-> !selectN && holdN)
		else $error("output enabled outside a selection");
	AST_HOLD_FREEZE: assert property ((!holdN) [*6] |-> $stable(soData) && $stable(statusReg))
		else $error("state moved during hold");
	AST_MODE_PICK: assert property ($fell(selectN) && holdN |-> ##6 spiMode3 == $past(sckPin, 6))
		else $error("mode not taken from clock level at select");
	// Protected bits must not move once the pin has been low long enough to pass the synchroniser
	AST_WP_LOCK: assert property (wpLow >= 8 && $past(statusReg[SR_PPEN]) |-> statusReg[7:2] == $past(statusReg[7:2]))
		else $error("status written while pin protected");
endmodule : fsp_port_props

// ==== verif/fsp_spi_master.sv ====
// SPI master model with a 48 ns serial period.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module fsp_spi_master
(
	// Reference clock, only to place the link phase
	input wire logic clock,
	// SPI pins
	output logic sckPin,
	output logic selectN,
	output logic siPin,
	output logic holdN,
	input wire logic soData,
	input wire logic soOe
);
	bit m3;
	// Idle pins: deselected, hold released
	initial
	begin
		sckPin = 1'b0;
		selectN = 1'b1;
		siPin = 1'b0;
		holdN = 1'b1;
	end
	// Odd offset keeps link edges off the system clock edges
	task automatic frameStart(input bit mode3);
		@(posedge clock);
		#1.3;
		m3 = mode3;
		sckPin = mode3;
		#24;
		selectN = 1'b0;
		#24;
	endtask : frameStart
	// Byte MSB first; a released output reads as z
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sckPin = 1'b0;
			siPin = tx[i];
			#24;
			sckPin = 1'b1;
			rx[i] = soOe ? soData : 1'bz;
			#24;
		end
	endtask : xfer
	// Clock parks at the mode level; SI flips so stale data never looks valid
	task automatic frameEnd();
		sckPin = m3;
		#24;
		selectN = 1'b1;
		siPin = ~siPin;
		#48;
	endtask : frameEnd
	// Hold with the clock low, clock toggled meanwhile and must be ignored
	task automatic pause();
		sckPin = 1'b0;
		#24;
		holdN = 1'b0;
		repeat (3)
		begin
			#24;
			sckPin = 1'b1;
			#24;
			sckPin = 1'b0;
		end
		#24;
		holdN = 1'b1;
		#24;
	endtask : pause
endmodule : fsp_spi_master

// ==== verif/test_serial_fram_spi_slave_port.sv ====
// Self-checking bench for the serial memory SPI slave port.
// Assumes the design, the checker and the master model are compiled first.
`timescale 1ns/1ps
module test_serial_fram_spi_slave_port
	import fsp_pkg::*;
;
	localparam logic [31:0] ID_VAL = 32'h13572468; // Arbitrary identification value
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic writeProtectN = 1'b1;
	logic sckPin, selectN, siPin, holdN, soData, soOe, spiMode3;
	logic [7:0] statusReg;
	int err_total = 0;
	int cmp_count = 0;
	logic [7:0] rq[$];
	fsp_port #(.ID_CODE(ID_VAL)) dut (.clock(clock), .rst_n(rst_n), .sckPin(sckPin), .selectN(selectN),
		.siPin(siPin), .soData(soData), .soOe(soOe), .writeProtectN(writeProtectN), .holdN(holdN),
		.spiMode3(spiMode3), .statusReg(statusReg));
	fsp_spi_master master (.clock(clock), .sckPin(sckPin), .selectN(selectN), .siPin(siPin),
		.holdN(holdN), .soData(soData), .soOe(soOe));
	// 200 MHz clock
	initial
	begin
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize();
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// One selection: send bytes, hold before read byte h, collect n bytes
	task automatic frame(input bit m3, input logic [7:0] tx[$], input int n, input int h = -1);
		logic [7:0] b;
		rq.delete();
		master.frameStart(m3);
		foreach (tx[i])
			master.xfer(tx[i], b);
		for (int i = 0; i < n; i++)
		begin
			if (i == h)
				master.pause();
			master.xfer(8'h00, b);
			rq.push_back(b);
		end
		master.frameEnd();
		chk("mode", {7'h00, m3}, {7'h00, spiMode3});
	endtask : frame
	task automatic sr(input logic [7:0] v);
		frame(0, {OP_WRITE_ENABLE}, 0);
		frame(0, {OP_WRITE_STATUS, v}, 0);
	endtask : sr
	task automatic t_write();
		frame(0, {OP_WRITE_ENABLE}, 0);
		chk("latch", 8'h02, statusReg);
		frame(0, {OP_WRITE, 8'hFC, 8'h00, 8'h10, 8'hA5, 8'h3C}, 0);
		chk("latch", 8'h00, statusReg);
		frame(1, {OP_READ, 8'h00, 8'h00, 8'h10}, 2);
		chk("rd0", 8'hA5, rq[0]);
		chk("rd1", 8'h3C, rq[1]);
	endtask : t_write
	task automatic t_disable();
		frame(0, {OP_WRITE_ENABLE}, 0);
		frame(0, {OP_WRITE_DISABLE}, 0);
		chk("cleared", 8'h00, statusReg);
		frame(0, {OP_WRITE, 8'h00, 8'h00, 8'h10, 8'h5A}, 0);
		frame(1, {OP_READ, 8'h00, 8'h00, 8'h10}, 1);
		chk("kept", 8'hA5, rq[0]);
	endtask : t_disable
	// Each protect code: byte below the base per code taken for codes 1 and 2, refused for code 3, base itself refused
	task automatic t_block();
		logic [23:0] a;
		logic [23:0] base[3] = '{24'h030000, 24'h020000, 24'h000001};
		for (int k = 1; k <= 3; k++)
		begin
			a = base[k-1] - 24'h000001;
			sr(8'h00);
			frame(0, {OP_WRITE_ENABLE}, 0);
			frame(0, {OP_WRITE, a[23:16], a[15:8], a[7:0], 8'h40, 8'h50 + 8'(k)}, 0);
			sr(8'(k << 2));
			chk("bp", 8'(k << 2), statusReg);
			frame(0, {OP_WRITE_ENABLE}, 0);
			frame(0, {OP_WRITE, a[23:16], a[15:8], a[7:0], 8'h22, 8'h77}, 0);
			frame(1, {OP_READ, a[23:16], a[15:8], a[7:0]}, 2);
			chk("below", k == 3 ? 8'h40 : 8'h22, rq[0]);
			chk("base", 8'h50 + 8'(k), rq[1]);
		end
		sr(8'h00);
	endtask : t_block
	task automatic t_wp();
		sr(8'h84);
		chk("sr", 8'h84, statusReg);
		@(posedge clock);
		writeProtectN <= 1'b0;
		sr(8'h00);
		chk("locked", 8'h84, statusReg);
		frame(1, {OP_READ_STATUS}, 1);
		chk("rdsr", 8'h84, rq[0]);
		@(posedge clock);
		writeProtectN <= 1'b1;
		sr(8'h00);
		chk("unlocked", 8'h00, statusReg);
	endtask : t_wp
	task automatic t_misc();
		frame(1, {OP_READ_ID}, 4);
		for (int i = 0; i < 4; i++)
			chk("id", ID_VAL[31-8*i -: 8], rq[i]);
		frame(0, {8'hFF, OP_READ, 8'h00, 8'h00}, 2);
		chk("quiet", 8'hzz, rq[1]);
		frame(0, {OP_FAST_READ, 8'h00, 8'h00, 8'h10, 8'h00}, 2, 1);
		chk("held0", 8'hA5, rq[0]);
		chk("held1", 8'h3C, rq[1]);
	endtask : t_misc
	// Reset for six cycles, then every scenario
	initial
	begin
		repeat (6) @(posedge clock);
		chk("rst", SR_RESET, statusReg);
		chk("oe", 8'h00, {7'h00, soOe});
		rst_n <= 1'b1;
		t_write();
		t_disable();
		t_block();
		t_wp();
		t_misc();
		summarize();
	end
endmodule : test_serial_fram_spi_slave_port
bind fsp_port fsp_port_props props (.clock(clock), .rst_n(rst_n), .sckPin(sckPin), .selectN(selectN),
	.siPin(siPin), .soData(soData), .soOe(soOe), .writeProtectN(writeProtectN), .holdN(holdN),
	.spiMode3(spiMode3), .statusReg(statusReg));
